/* File: rtl/mpsm_core.sv */
// Module power state machine with Avalon-MM register slave
`timescale 1ns/1ps

module mpsm_core
  import mpsm_pkg::*;
(
  input  wire logic              i_mclk,        // 250 MHz clock
  input  wire logic              i_sys_rst,     // Synchronous reset, active high
  input  wire mpsm_avm_req_t     i_avm,         // Avalon-MM request
  output logic                   o_waitrequest, // Held until the answer cycle
  output logic [31:0]            o_readdata,    // Read data
  input  wire logic              i_reset_sig,   // Reset transition signal, pin
  input  wire logic              i_hazard,      // Damaging condition detected, pin
  input  wire logic [NUM_DP-1:0] i_lane_done,   // Lane configuration finished per path
  output logic [2:0]             o_module_state,// Current state code
  output logic                   o_high_power,  // High-power current allowed
  output logic                   o_int          // State-changed interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // State and next state
  mpsm_regs_t r;       // Registered state
  mpsm_regs_t next_r;  // Next value

  // Low-power and extended request as seen by the machine
  logic lp_req;
  logic lpext_req;
  logic rst_req;   // Filtered reset transition signal
  logic flt_req;   // Filtered hazard
  logic wr_hit;    // Accepted write this cycle
  logic rd_hit;    // Accepted read this cycle

  // Compare two byte addresses on their word bits [7:2], used for reads and writes
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    is_addr = (a[7:2] == b[7:2]);
  endfunction : is_addr

  // Pack per-path states into a read word
  function automatic logic [31:0] pack_dp(input mpsm_dp_t [NUM_DP-1:0] d);
    pack_dp = 32'h0;
    for (int i = 0; i < NUM_DP; i++) begin
      pack_dp[2*i +: 2] = d[i];
    end
  endfunction : pack_dp

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers
  always_comb begin
    lp_req    = r.ctl[CTL_LOWPWR_BIT];
    lpext_req = r.ctl[CTL_LOWPWR_BIT] | r.ctl[CTL_LPEXT_BIT];
    // Request counts while second and third stages are both high
    rst_req   = r.rst_sync[1] & r.rst_sync[2];
    flt_req   = r.flt_sync[1] & r.flt_sync[2];
    wr_hit    = i_avm.write & ~r.ack;
    rd_hit    = i_avm.read & ~r.ack;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    // Three-stage input synchronisers
    next_r.rst_sync = {r.rst_sync[1:0], i_reset_sig};
    next_r.flt_sync = {r.flt_sync[1:0], i_hazard};

    // Register accesses; one wait cycle, answer on the next edge
    if (wr_hit) begin
      next_r.ack = 1'b1;
      // Fault and resetting ignore host writes
      if (r.state != MPSM_ST_FAULT && r.state != MPSM_ST_RESETTING &&
          r.state != MPSM_ST_MGMT_INIT) begin
        if (is_addr(i_avm.address, ADDR_FLAGS) && i_avm.writedata[0]) begin
          next_r.chg_flag = 1'b0;
        end
        if (is_addr(i_avm.address, ADDR_CONTROL)) begin
          next_r.ctl = i_avm.writedata[2:0];
        end
        // Path config changes only in low-power or operational
        if (is_addr(i_avm.address, ADDR_DP_CFG) &&
            (r.state == MPSM_ST_LOWPWR || r.state == MPSM_ST_READY)) begin
          next_r.dp_cfg = i_avm.writedata[7:0];
          for (int i = 0; i < NUM_DP; i++) begin
            // Remove undefined ones, then create new ones
            if (!i_avm.writedata[DPC_DEF_LSB+i]) begin
              next_r.dp[i] = MPSM_DP_NONE;
            end else if (r.dp[i] == MPSM_DP_NONE) begin
              next_r.dp[i] = MPSM_DP_OFF;
            end
          end
        end
      end
    end else if (rd_hit) begin
      next_r.ack = 1'b1;
    end
    // Read data captured on the accept cycle
    if (rd_hit) begin
      next_r.rdata = 32'h0;
      if (is_addr(i_avm.address, ADDR_STATE)) begin
        next_r.rdata[2:0] = r.state;
      end else if (is_addr(i_avm.address, ADDR_FLAGS)) begin
        next_r.rdata[0] = r.chg_flag;
      end else if (is_addr(i_avm.address, ADDR_CONTROL)) begin
        next_r.rdata[2:0] = r.ctl;
      end else if (is_addr(i_avm.address, ADDR_CAUSE)) begin
        next_r.rdata[7:0] = r.cause;
      end else if (is_addr(i_avm.address, ADDR_DP_CFG)) begin
        next_r.rdata[7:0] = r.dp_cfg;
      end else if (is_addr(i_avm.address, ADDR_DP_STATE)) begin
        next_r.rdata = pack_dp(r.dp);
      end
    end

    // Counter runs down to zero
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - CNT_W'(1);
    end

    // Module state machine
    case (r.state)
      MPSM_ST_RESETTING: begin
        next_r.dp = '{default: MPSM_DP_NONE};
        // Stay while reset signal holds, then initialise management
        if (!rst_req) begin
          next_r.state = MPSM_ST_MGMT_INIT;
          next_r.cnt   = CNT_W'(INIT_CYCLES);
        end
      end
      MPSM_ST_MGMT_INIT: begin
        if (r.cnt == '0) begin
          // Defaults restored on exit
          next_r.ctl    = CTL_RESET_VAL;
          next_r.dp_cfg = DPC_RESET_VAL;
          next_r.cause  = CAUSE_NONE;
          next_r.dp_pend = '0;
          for (int i = 0; i < NUM_DP; i++) begin
            // Paths only in paged mode
            next_r.dp[i] = CTL_RESET_VAL[CTL_PAGED_BIT] && DPC_RESET_VAL[i] ?
                           MPSM_DP_OFF : MPSM_DP_NONE;
          end
          next_r.state = MPSM_ST_LOWPWR;
          // Flag unless exit already met on entry
          next_r.chg_flag = r.chg_flag | CTL_RESET_VAL[CTL_LOWPWR_BIT];
        end
      end
      MPSM_ST_LOWPWR: begin
        // Sampled every cycle, including the first
        if (!lp_req) begin
          next_r.state = MPSM_ST_PWRUP;
          next_r.cnt   = CNT_W'(RAMP_CYCLES);
        end
      end
      MPSM_ST_PWRUP: begin
        if (lp_req) begin
          next_r.state = MPSM_ST_PWRDN;
          next_r.cnt   = CNT_W'(RAMP_CYCLES);
        end else if (r.cnt == '0) begin
          next_r.state    = MPSM_ST_READY;
          next_r.chg_flag = 1'b1;
        end
      end
      MPSM_ST_READY: begin
        if (lpext_req) begin
          next_r.state = MPSM_ST_PWRDN;
          next_r.cnt   = CNT_W'(RAMP_CYCLES);
        end
      end
      MPSM_ST_PWRDN: begin
        // Request ignored until low power reached
        if (r.cnt == '0) begin
          next_r.state = MPSM_ST_LOWPWR;
          // Flag unless the request is already gone at entry
          if (lp_req) begin
            next_r.chg_flag = 1'b1;
          end
        end
      end
      MPSM_ST_FAULT: begin
        // Only the reset signal leaves, handled below
        next_r.state = MPSM_ST_FAULT;
      end
      default: begin
        next_r.state = MPSM_ST_RESETTING;
      end
    endcase

    // Data paths: off outside operational; activation waits on all lanes
    for (int i = 0; i < NUM_DP; i++) begin
      if (next_r.dp[i] != MPSM_DP_NONE) begin
        if (!r.ctl[CTL_PAGED_BIT]) begin
          next_r.dp[i] = MPSM_DP_NONE;
        end else if (next_r.state != MPSM_ST_READY || !next_r.dp_cfg[DPC_EN_LSB+i]) begin
          next_r.dp[i]      = MPSM_DP_OFF;
          next_r.dp_pend[i] = 1'b0;
        end else if (r.dp[i] == MPSM_DP_OFF) begin
          // Each path moves on its own lanes only
          next_r.dp_pend[i] = 1'b1;
          if (r.dp_pend[i] && i_lane_done[i]) begin
            next_r.dp[i]      = MPSM_DP_ACTIVE;
            next_r.dp_pend[i] = 1'b0;
          end
        end
      end
    end

    // Hazard enters fault from any running state
    if (flt_req && r.state != MPSM_ST_FAULT && r.state != MPSM_ST_RESETTING &&
        r.state != MPSM_ST_MGMT_INIT) begin
      next_r.state = MPSM_ST_FAULT;
      next_r.cause = CAUSE_HAZARD;
      next_r.dp    = '{default: MPSM_DP_OFF};
      next_r.dp_pend = '0;
    end
    // Reset signal overrides everything
    if (rst_req && r.state != MPSM_ST_RESETTING) begin
      next_r.state = MPSM_ST_RESETTING;
      next_r.dp    = '{default: MPSM_DP_NONE};
      next_r.dp_pend = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      r          <= '0;
      r.state    <= MPSM_ST_MGMT_INIT;
      r.cnt      <= CNT_W'(INIT_CYCLES);
      r.ctl      <= CTL_RESET_VAL;
      r.dp_cfg   <= DPC_RESET_VAL;
      r.dp       <= '{default: MPSM_DP_NONE};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    o_waitrequest  = (i_avm.read | i_avm.write) & ~r.ack;
    o_readdata     = r.rdata;
    o_module_state = r.state;
    // High power only while ramping or operational; fault drops it
    o_high_power   = (r.state == MPSM_ST_PWRUP) || (r.state == MPSM_ST_READY) ||
                     (r.state == MPSM_ST_PWRDN);
    o_int          = r.chg_flag;
  end

endmodule : mpsm_core

/* File: shared/mpsm_pkg.sv */
// Package for the module power state machine: register map, codes, timing, carriers
//
// What this block does
// - Low-power entry records state, flags unless leaving
// - Low-power state keeps serving management accesses
// - Sample low-power request continuously, leave when false
// - Data paths deactivated in low-power, power-up, power-down
// - Power-up entry writes power-up state code
// - Low-power request during power-up goes power-down
// - Finished power-up sequence goes fully operational
// - Operational entry records state, always flags
// - Operational leaves on low-power or extended low-power request
// - Power-down entry writes power-down state code
// - Power down, keep management alive, then low-power
// - Ignore low-power request throughout power-down
// - Fault entry writes fault code and cause
// - Fault only on hazard, drop to low power
// - In fault react only to reset signal
// - Only reset signal or power cycle leaves fault
// - Data paths stay off until operational and enabled
// - Config change removes old, then creates new paths
// - Resetting discards all data-path state machines
// - Report path state after all lanes finish
// - One path change leaves other paths undisturbed
// - Data paths exist only in paged memory mode
// - Reset signal enters resetting from any state
// - Management init ends in low-power with defaults
package mpsm_pkg;

  // Number of data paths handled here
  localparam int unsigned NUM_DP = 4;

  // Word-aligned register byte addresses
  localparam logic [7:0] ADDR_STATE    = 8'h00;  // Module state code, read only
  localparam logic [7:0] ADDR_FLAGS    = 8'h04;  // Bit 0 state changed, write 1 to clear
  localparam logic [7:0] ADDR_CONTROL  = 8'h08;  // Low-power request controls
  localparam logic [7:0] ADDR_CAUSE    = 8'h0C;  // Fault cause code, read only
  localparam logic [7:0] ADDR_DP_CFG   = 8'h10;  // Defined paths and enables
  localparam logic [7:0] ADDR_DP_STATE = 8'h14;  // Per-path state, 2 bits each

  // Control register fields
  localparam int unsigned CTL_LOWPWR_BIT = 0;  // Low-power request
  localparam int unsigned CTL_LPEXT_BIT  = 1;  // Extended low-power request
  localparam int unsigned CTL_PAGED_BIT  = 2;  // Paged memory organisation
  localparam logic [2:0]  CTL_RESET_VAL  = 3'h5;  // Low power requested, paged

  // Data-path config fields: defined bits [3:0], enable bits [7:4]
  localparam int unsigned DPC_DEF_LSB = 0;
  localparam int unsigned DPC_EN_LSB  = 4;
  localparam logic [7:0]  DPC_RESET_VAL = 8'h0F;

  // Fault cause codes: none, or an external hazard input
  localparam logic [7:0] CAUSE_NONE    = 8'h00;
  localparam logic [7:0] CAUSE_HAZARD  = 8'h01;

  // Timing: power ramps and management init
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_INIT_NS     = 200;
  localparam int unsigned T_RAMP_NS     = 400;
  localparam int unsigned INIT_CYCLES   = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAMP_CYCLES   = (T_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 8;

  // Module state codes as seen by software
  typedef enum logic [2:0] {
    MPSM_ST_RESETTING = 3'h0,
    MPSM_ST_MGMT_INIT = 3'h1,
    MPSM_ST_LOWPWR    = 3'h2,
    MPSM_ST_PWRUP     = 3'h3,
    MPSM_ST_READY     = 3'h4,
    MPSM_ST_PWRDN     = 3'h5,
    MPSM_ST_FAULT     = 3'h6
  } mpsm_state_t;

  // Per-path state codes
  typedef enum logic [1:0] {
    MPSM_DP_NONE   = 2'h0,  // Not existing
    MPSM_DP_OFF    = 2'h1,  // Deactivated
    MPSM_DP_ACTIVE = 2'h3   // Activated
  } mpsm_dp_t;

  // Avalon-MM request group
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } mpsm_avm_req_t;

  // Whole state of the block
  typedef struct packed {
    mpsm_state_t            state;
    logic [CNT_W-1:0]       cnt;
    logic                   chg_flag;
    logic [7:0]             cause;
    logic [2:0]             ctl;
    logic [7:0]             dp_cfg;
    mpsm_dp_t [NUM_DP-1:0]  dp;
    logic [NUM_DP-1:0]      dp_pend;
    logic                   ack;
    logic [31:0]            rdata;
    logic [2:0]             rst_sync;
    logic [2:0]             flt_sync;
  } mpsm_regs_t;

endpackage : mpsm_pkg

/* File: testbench/mpsm_core_props.sv */
// Checker with concurrent properties on the power state machine ports
`timescale 1ns/1ps

module mpsm_core_props
  import mpsm_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_sys_rst,
  input wire mpsm_avm_req_t     i_avm,
  input wire logic              o_waitrequest,
  input wire logic [31:0]       o_readdata,
  input wire logic              i_reset_sig,
  input wire logic              i_hazard,
  input wire logic [NUM_DP-1:0] i_lane_done,
  input wire logic [2:0]        o_module_state,
  input wire logic              o_high_power,
  input wire logic              o_int
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // One wait cycle per access, so a stuck slave shows at once
  AST_ONE_WAIT: assert property ((i_avm.read | i_avm.write) && o_waitrequest |=> !o_waitrequest)
    else $error("waitrequest held too long");
  AST_FAULT_LOW: assert property (o_module_state == MPSM_ST_FAULT |-> !o_high_power)
    else $error("high power in fault");
  AST_READY_FLAG: assert property ($rose(o_module_state == MPSM_ST_READY) |-> ##[0:1] o_int)
    else $error("no flag on ready entry");
  AST_PWRUP_SRC: assert property ($rose(o_module_state == MPSM_ST_PWRUP)
    |-> $past(o_module_state) == MPSM_ST_LOWPWR)
    else $error("power-up not from low power");
  AST_READY_SRC: assert property ($rose(o_module_state == MPSM_ST_READY)
    |-> $past(o_module_state) == MPSM_ST_PWRUP)
    else $error("ready not from power-up");
  AST_LOWPWR_SRC: assert property ($rose(o_module_state == MPSM_ST_LOWPWR)
    |-> $past(o_module_state) inside {MPSM_ST_MGMT_INIT, MPSM_ST_PWRDN})
    else $error("bad entry to low power");
  // Power-down holds for at least 8 cycles whatever the request does meanwhile
  AST_PWRDN_RUN: assert property ($rose(o_module_state == MPSM_ST_PWRDN)
    |-> (o_module_state == MPSM_ST_PWRDN) [*8])
    else $error("power-down cut short");
  AST_FAULT_STAY: assert property (o_module_state == MPSM_ST_FAULT
    |=> o_module_state inside {MPSM_ST_FAULT, MPSM_ST_RESETTING})
    else $error("fault left without reset");
  AST_RST_ENTRY: assert property ($rose(i_reset_sig) |-> ##[1:6] o_module_state == MPSM_ST_RESETTING)
    else $error("reset signal ignored");
  AST_INT_HOLD: assert property ($fell(o_int) |-> $past(i_avm.write && i_avm.address == ADDR_FLAGS)
    || o_module_state inside {MPSM_ST_RESETTING, MPSM_ST_MGMT_INIT})
    else $error("flag dropped without clear");
  COV_READY: cover property ($rose(o_module_state == MPSM_ST_READY));
  COV_ABORT: cover property (o_module_state == MPSM_ST_PWRUP ##1 o_module_state == MPSM_ST_PWRDN);
  COV_FAULT: cover property ($rose(o_module_state == MPSM_ST_FAULT));
endmodule : mpsm_core_props

bind mpsm_core mpsm_core_props u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_avm(i_avm),
  .o_waitrequest(o_waitrequest), .o_readdata(o_readdata), .i_reset_sig(i_reset_sig),
  .i_hazard(i_hazard), .i_lane_done(i_lane_done), .o_module_state(o_module_state),
  .o_high_power(o_high_power), .o_int(o_int));

/* File: testbench/mpsm_host_model.sv */
// Host management controller: Avalon-MM master with register access tasks
`timescale 1ns/1ps

module mpsm_host_model
  import mpsm_pkg::*;
(
  input  wire logic          i_mclk,
  output mpsm_avm_req_t      o_avm,
  input  wire logic          i_waitrequest,
  input  wire logic [31:0]   i_readdata
);
  initial o_avm = '0;  // Idle bus from time zero
  ////////////////////////////////////////////////////////////////////////
  // Hold the request until waitrequest is seen low at a rising edge
  task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_mclk);
    o_avm <= '{address: a, read: rd, write: !rd, writedata: d};
    // Read right after the edge, before the slave's update lands: the sampled values
    do begin
      @(posedge i_mclk);
      n++;
    end while (i_waitrequest !== 1'b0 && n < 200);
    // Read data stands at the same edge that ends the wait
    q = i_readdata;
    // Release only after the answering edge
    o_avm <= '0;
    if (n >= 200) begin
      testbench.err_total++;
      testbench.test_done();
    end
  endtask : access
endmodule : mpsm_host_model

/* File: testbench/testbench.sv */
// Self-checking bench for the module power state machine
`timescale 1ns/1ps

module testbench;
  import mpsm_pkg::*;
  logic              clk = 1'b0;      // 250 MHz
  logic              rst = 1'b1;      // Synchronous reset
  logic              rsig = 1'b0;     // Reset transition pin
  logic              hz = 1'b0;       // Hazard pin
  logic [NUM_DP-1:0] done = '0;       // Lane completion per path
  mpsm_avm_req_t     avm;
  logic              wreq;
  logic [31:0]       rdat, q;
  logic [2:0]        st;
  logic              hp, irq;
  int                err_total = 0;
  int                tests_run = 0;

  always #2 clk = ~clk;

  mpsm_core dut (.i_mclk(clk), .i_sys_rst(rst), .i_avm(avm), .o_waitrequest(wreq),
    .o_readdata(rdat), .i_reset_sig(rsig), .i_hazard(hz), .i_lane_done(done),
    .o_module_state(st), .o_high_power(hp), .o_int(irq));
  mpsm_host_model host (.i_mclk(clk), .o_avm(avm), .i_waitrequest(wreq), .i_readdata(rdat));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.access(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.access(1'b1, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  // Bounded wait for a state; running out ends the run
  task automatic wait_st(input mpsm_state_t s);
    int n;
    for (n = 0; n < 400 && st !== s; n++) @(negedge clk);
    chk({29'h0, st}, {29'h0, s});
    if (st !== s) test_done();
  endtask : wait_st

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({st, hp, irq}, {MPSM_ST_MGMT_INIT, 2'b00});
    rd(ADDR_CONTROL, 32'h5);
    rd(ADDR_DP_CFG, 32'h0F);
    rd(8'h18, 32'h0);
    wait_st(MPSM_ST_LOWPWR);
    chk(irq, 1'b1);
    rd(ADDR_DP_STATE, 32'h55);
    wr(ADDR_FLAGS, 32'h1);
    chk(irq, 1'b0);
    wr(ADDR_STATE, 32'h4);
    rd(ADDR_STATE, 32'h2);
    $display("Test init done");
    // Abort power-up, then drop the request inside power-down
    wr(ADDR_CONTROL, 32'h4);
    wait_st(MPSM_ST_PWRUP);
    chk(hp, 1'b1);
    wr(ADDR_CONTROL, 32'h5);
    wait_st(MPSM_ST_PWRDN);
    rd(ADDR_DP_STATE, 32'h55);
    wr(ADDR_CONTROL, 32'h4);
    chk(st, MPSM_ST_PWRDN);
    wait_st(MPSM_ST_LOWPWR);
    wait_st(MPSM_ST_PWRUP);
    wr(ADDR_FLAGS, 32'h1);
    wait_st(MPSM_ST_READY);
    chk(irq, 1'b1);
    $display("Test power-up done");
    // Paths: report only after lanes finish, others untouched
    wr(ADDR_DP_CFG, 32'h1F);
    rd(ADDR_DP_STATE, 32'h55);
    @(posedge clk) done <= 4'h1;
    repeat (4) @(posedge clk);
    rd(ADDR_DP_STATE, 32'h57);
    wr(ADDR_DP_CFG, 32'h13);
    rd(ADDR_DP_STATE, 32'h07);
    wr(ADDR_CONTROL, 32'h6);
    wait_st(MPSM_ST_PWRDN);
    wr(ADDR_CONTROL, 32'h5);
    wr(ADDR_FLAGS, 32'h1);
    wait_st(MPSM_ST_LOWPWR);
    chk(irq, 1'b1);
    rd(ADDR_DP_STATE, 32'h05);
    $display("Test paths done");
    // Fault holds until the reset transition signal
    @(posedge clk) hz <= 1'b1;
    wait_st(MPSM_ST_FAULT);
    rd(ADDR_CAUSE, {24'h0, CAUSE_HAZARD});
    wr(ADDR_CONTROL, 32'h4);
    @(posedge clk) hz <= 1'b0;
    repeat (150) @(posedge clk);
    rd(ADDR_STATE, 32'h6);
    chk(hp, 1'b0);
    @(posedge clk) rsig <= 1'b1;
    wait_st(MPSM_ST_RESETTING);
    rd(ADDR_DP_STATE, 32'h0);
    @(posedge clk) rsig <= 1'b0;
    wait_st(MPSM_ST_MGMT_INIT);
    wait_st(MPSM_ST_LOWPWR);
    rd(ADDR_CONTROL, 32'h5);
    $display("Test fault done");
    test_done();
  end
endmodule : testbench
